// file: run_stop_pkg.sv
// Purpose: Shared constants and types for the run/stop mode arbiter.
// Assumes: APB register window of 12 address bits, 32-bit data.
// Notes: All offsets and field positions live here, and the enable, select and forced-mode reset values.
package run_stop_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h004;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int SEL_W = 4;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SEL_LSB = 1;
    localparam int CTRL_FMODE_BIT = 8;
    localparam int CTRL_FRUN_BIT = 9;
    localparam int CTRL_FSTOP_BIT = 10;
    localparam logic CTRL_EN_RESET = 1'b0;
    localparam logic [SEL_W-1:0] CTRL_SEL_RESET = 4'h0;
    localparam logic CTRL_FMODE_RESET = 1'b0;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_RSTOP_BIT = 1;
    localparam int STAT_RRUN_BIT = 2;
    localparam int STAT_SW_BIT = 3;
    localparam int STAT_RI_BIT = 4;
    localparam int STAT_FLATCH_BIT = 5;

    // ------------------------------------------------------------------
    // Input terminal counts
    // ------------------------------------------------------------------
    localparam int RUN_INPUTS_FULL = 16;
    localparam int RUN_INPUTS_SMALL = 8;

    // ------------------------------------------------------------------
    // Remote command state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        REMOTE_NONE,
        REMOTE_RUN,
        REMOTE_STOP
    } remote_t;

endpackage

// file: level_sync_rise.sv
// Purpose: Two-stage synchroniser with a rising-edge pulse.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module level_sync_rise (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic level,
    output logic rise
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic next_stage1;
    logic next_stage2;
    logic next_stage3;

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    always_comb begin
        next_stage1 = din;
        next_stage2 = stage1;
        next_stage3 = stage2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
        end
    end

    assign level = stage2;
    assign rise = stage2 & ~stage3;

    a_rise_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        rise |=> !rise) else $error("Rise pulse lasted more than one cycle.");

endmodule // level_sync_rise

// file: run_stop_arbiter.sv
// Purpose: Decides running or stopped from switch, run input and remote commands.
// Assumes: pclk at 100 MHz, presetn asynchronous active low, APB slave with no waits.
// Notes: Remote commands arrive as one-cycle pulses from the programming link logic.
//
// Summary of operation
// - Outside forced run mode, the front-panel switch in run runs the device; in stop it leaves the decision to the run input.
// - A control field picks one input terminal, 0 to 15 or 0 to 7 on the small part.
// - Outside forced run mode, the device runs when the picked, enabled run input or the switch asks for run.
// - Separate run and stop buttons work only via the program-driven request relays.
// - Remote run and remote stop commands force the running or stopped state.
// - Reset discards any remote state, leaving only switch and run input in charge.
// - After a remote stop a remote run command brings the device back to running.
// - After a remote stop, taking switch or run input to stop and back to run resumes.
`timescale 1ns/1ps
module run_stop_arbiter
    import run_stop_pkg::*;
#(
    parameter int NUM_INPUTS = RUN_INPUTS_FULL
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic run_switch,
    input wire logic [NUM_INPUTS-1:0] input_terminals,
    input wire logic remote_run_cmd,
    input wire logic remote_stop_cmd,
    output logic running
);

    logic run_in_en;
    logic [SEL_W-1:0] run_sel;
    logic forced_run_mode_relay;
    logic forced_run_request_relay;
    logic forced_stop_request_relay;
    logic forced_latch;
    remote_t remote_state;
    logic next_run_in_en;
    logic [SEL_W-1:0] next_run_sel;
    logic next_forced_run_mode_relay;
    logic next_forced_run_request_relay;
    logic next_forced_stop_request_relay;
    logic next_forced_latch;
    remote_t next_remote_state;
    logic next_running;
    logic [31:0] next_prdata;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic sel_valid;
    logic sel_x;
    logic [(2**SEL_W)-1:0] terminals_wide;
    logic sw_lvl;
    logic sw_rise;
    logic ri_lvl;
    logic ri_rise;
    logic local_run;
    logic restart;
    logic wr_ctrl;
    logic seen_cmd;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign pready = 1'b1;
    assign wr_ctrl = psel & penable & pwrite & (paddr == ADDR_CTRL);
    assign pslverr = psel & penable & (paddr != ADDR_CTRL) & (paddr != ADDR_STAT);

    // ------------------------------------------------------------------
    // Run input selection and synchronisers
    // ------------------------------------------------------------------
    assign sel_valid = int'(run_sel) < NUM_INPUTS;
    // Widened so that every select code indexes a real bit on the small part.
    assign terminals_wide = (2**SEL_W)'(input_terminals);
    assign sel_x = sel_valid ? terminals_wide[run_sel] : 1'b0;

    level_sync_rise u_switch_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(run_switch),
        .level(sw_lvl),
        .rise(sw_rise)
    );

    level_sync_rise u_run_input_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(run_in_en & sel_x),
        .level(ri_lvl),
        .rise(ri_rise)
    );

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_word = 32'h00000000;
        ctrl_word[CTRL_EN_BIT] = run_in_en;
        ctrl_word[CTRL_SEL_LSB +: SEL_W] = run_sel;
        ctrl_word[CTRL_FMODE_BIT] = forced_run_mode_relay;
        stat_word = 32'h00000000;
        stat_word[STAT_RUN_BIT] = running;
        stat_word[STAT_RSTOP_BIT] = (remote_state == REMOTE_STOP);
        stat_word[STAT_RRUN_BIT] = (remote_state == REMOTE_RUN);
        stat_word[STAT_SW_BIT] = sw_lvl;
        stat_word[STAT_RI_BIT] = ri_lvl;
        stat_word[STAT_FLATCH_BIT] = forced_latch;
        next_run_in_en = run_in_en;
        next_run_sel = run_sel;
        next_forced_run_mode_relay = forced_run_mode_relay;
        next_forced_run_request_relay = 1'b0;
        next_forced_stop_request_relay = 1'b0;
        if (wr_ctrl) begin
            next_run_in_en = pwdata[CTRL_EN_BIT];
            next_run_sel = pwdata[CTRL_SEL_LSB +: SEL_W];
            next_forced_run_mode_relay = pwdata[CTRL_FMODE_BIT];
            next_forced_run_request_relay = pwdata[CTRL_FRUN_BIT];
            next_forced_stop_request_relay = pwdata[CTRL_FSTOP_BIT];
        end
        next_prdata = prdata;
        if (psel && !penable) begin
            case (paddr)
                ADDR_CTRL: begin
                    next_prdata = ctrl_word;
                end
                ADDR_STAT: begin
                    next_prdata = stat_word;
                end
                default: begin
                    next_prdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_in_en <= CTRL_EN_RESET;
            run_sel <= CTRL_SEL_RESET;
            forced_run_mode_relay <= CTRL_FMODE_RESET;
            forced_run_request_relay <= 1'b0;
            forced_stop_request_relay <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            run_in_en <= next_run_in_en;
            run_sel <= next_run_sel;
            forced_run_mode_relay <= next_forced_run_mode_relay;
            forced_run_request_relay <= next_forced_run_request_relay;
            forced_stop_request_relay <= next_forced_stop_request_relay;
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------------
    // Run/stop decision
    // ------------------------------------------------------------------
    always_comb begin
        local_run = forced_run_mode_relay ? forced_latch : (sw_lvl | ri_lvl);
        restart = sw_rise | ri_rise;
        next_forced_latch = forced_latch;
        if (!forced_run_mode_relay) begin
            next_forced_latch = 1'b0;
        end else if (forced_stop_request_relay) begin
            next_forced_latch = 1'b0;
        end else if (forced_run_request_relay) begin
            next_forced_latch = 1'b1;
        end
        next_remote_state = remote_state;
        if (remote_stop_cmd) begin
            next_remote_state = REMOTE_STOP;
        end else if (remote_run_cmd) begin
            next_remote_state = REMOTE_RUN;
        end else if (restart && remote_state == REMOTE_STOP) begin
            next_remote_state = REMOTE_NONE;
        end
        case (next_remote_state)
            REMOTE_RUN: begin
                next_running = 1'b1;
            end
            REMOTE_STOP: begin
                next_running = 1'b0;
            end
            default: begin
                next_running = local_run;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            forced_latch <= 1'b0;
            remote_state <= REMOTE_NONE;
            running <= 1'b0;
            seen_cmd <= 1'b0;
        end else begin
            forced_latch <= next_forced_latch;
            remote_state <= next_remote_state;
            running <= next_running;
            seen_cmd <= seen_cmd | remote_run_cmd | remote_stop_cmd;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_switch_runs: assert property (@(posedge pclk) disable iff (!presetn)
        (sw_lvl && !forced_run_mode_relay && remote_state == REMOTE_NONE
         && !remote_stop_cmd) |=> running) else $error("Switch at run did not run.");
    a_idle_stops: assert property (@(posedge pclk) disable iff (!presetn)
        (!sw_lvl && !ri_lvl && !forced_run_mode_relay && remote_state == REMOTE_NONE
         && !remote_run_cmd && !remote_stop_cmd) |=> !running)
        else $error("Stopped sources did not stop.");
    a_sel_range: assert property (@(posedge pclk) disable iff (!presetn)
        !sel_valid [*2] |=> !ri_lvl)
        else $error("Out-of-range selection reached the run input.");
    a_run_input_runs: assert property (@(posedge pclk) disable iff (!presetn)
        (ri_lvl && !sw_lvl && !forced_run_mode_relay && remote_state == REMOTE_NONE
         && !remote_stop_cmd) |=> running) else $error("Run input did not run.");
    a_forced_latch: assert property (@(posedge pclk) disable iff (!presetn)
        (forced_run_mode_relay && forced_run_request_relay && !forced_stop_request_relay)
        |=> forced_latch) else $error("Run request relay ignored.");
    a_remote_stop: assert property (@(posedge pclk) disable iff (!presetn)
        remote_stop_cmd |=> (!running && remote_state == REMOTE_STOP))
        else $error("Remote stop did not stop.");
    a_remote_run: assert property (@(posedge pclk) disable iff (!presetn)
        (remote_run_cmd && !remote_stop_cmd) |=> running)
        else $error("Remote run did not run.");
    a_power_on_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !seen_cmd |-> remote_state == REMOTE_NONE)
        else $error("Remote state present without a command.");
    a_restart_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (restart && remote_state == REMOTE_STOP && !remote_stop_cmd && !remote_run_cmd)
        |=> remote_state == REMOTE_NONE) else $error("Restart edge kept remote stop.");
    a_switch_latency: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(sw_lvl) && !ri_lvl && !forced_run_mode_relay && !remote_run_cmd
         && !remote_stop_cmd && remote_state != REMOTE_RUN) |=> running)
        else $error("Switch edge did not resume running.");

    c_remote_stop_resume: cover property (@(posedge pclk) disable iff (!presetn)
        remote_state == REMOTE_STOP ##1 remote_state == REMOTE_NONE ##1 running);
    c_remote_run: cover property (@(posedge pclk) disable iff (!presetn)
        remote_run_cmd ##1 running && !sw_lvl);
    c_run_input: cover property (@(posedge pclk) disable iff (!presetn)
        ri_lvl && !sw_lvl ##1 running);
    c_forced_mode: cover property (@(posedge pclk) disable iff (!presetn)
        forced_run_mode_relay && forced_latch ##1 running);

endmodule // run_stop_arbiter

// file: field_partner.sv
// Purpose: Far-side model of the front-panel switch, field inputs and programming software.
// Assumes: The bench calls its tasks; every change lands just after a rising pclk edge.
// Notes: Remote commands are one-cycle pulses.
`timescale 1ns/1ps
module field_partner #(
    parameter int NUM_INPUTS = 16
) (
    input wire logic pclk,
    output logic run_switch,
    output logic [NUM_INPUTS-1:0] input_terminals,
    output logic remote_run_cmd,
    output logic remote_stop_cmd
);
    // ------------------------------------------------------------------
    // Power-up levels
    // ------------------------------------------------------------------
    initial begin
        run_switch = 1'b0;
        input_terminals = '0;
        remote_run_cmd = 1'b0;
        remote_stop_cmd = 1'b0;
    end

    // ------------------------------------------------------------------
    // Operator and software actions
    // ------------------------------------------------------------------
    // Sets the switch and field input levels.
    task automatic set_levels(input logic sw, input logic [NUM_INPUTS-1:0] t);
        @(posedge pclk);
        run_switch <= sw;
        input_terminals <= t;
    endtask

    // Puts both local sources at stop before remote operation.
    task automatic remote_mode();
        set_levels(1'b0, '0);
    endtask

    // Sends one remote command pulse.
    task automatic command(input logic run, input logic stop);
        @(posedge pclk);
        remote_run_cmd <= run;
        remote_stop_cmd <= stop;
        @(posedge pclk);
        remote_run_cmd <= 1'b0;
        remote_stop_cmd <= 1'b0;
    endtask
endmodule // field_partner

// file: testbench.sv
// Purpose: Self-checking bench for the run/stop mode arbiter.
// Assumes: APB slave answers with pready; far side modelled by field_partner.
// Notes: Random terminal selections come from a fixed seed.
`timescale 1ns/1ps
module testbench;
    import run_stop_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, running, err, sw, en;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] sel;
    logic [15:0] t;
    logic run_switch, remote_run_cmd, remote_stop_cmd;
    logic [15:0] input_terminals;
    logic running_s;
    int miscompares = 0;
    int check_count = 0;

    always #5 pclk = ~pclk;

    run_stop_arbiter #(.NUM_INPUTS(16)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_switch(run_switch),
        .input_terminals(input_terminals), .remote_run_cmd(remote_run_cmd),
        .remote_stop_cmd(remote_stop_cmd), .running(running));
    run_stop_arbiter #(.NUM_INPUTS(RUN_INPUTS_SMALL)) uut_small (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .run_switch(run_switch),
        .input_terminals(input_terminals[RUN_INPUTS_SMALL-1:0]),
        .remote_run_cmd(remote_run_cmd), .remote_stop_cmd(remote_stop_cmd),
        .running(running_s));
    field_partner #(.NUM_INPUTS(16)) far (.pclk(pclk), .run_switch(run_switch),
        .input_terminals(input_terminals), .remote_run_cmd(remote_run_cmd),
        .remote_stop_cmd(remote_stop_cmd));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    function automatic logic [31:0] stat_exp(logic r, logic rs, logic rr, logic s, logic ri,
        logic fl);
        return 32'({fl, ri, s, rr, rs, r});
    endfunction

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        void'($urandom(39352));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        settle(1);
        check("running", running, 0);
        check("pready", pready, 1);
        apb(0, ADDR_CTRL, 0);
        check("ctrl", rd, 0);
        apb(0, ADDR_STAT, 0);
        check("status", rd, 0);
        apb(0, 12'h008, 0);
        check("error", err, 1);
        check("unmapped", rd, 0);
        apb(1, ADDR_STAT, 32'hFFFF_FFFF);
        check("status write", err, 0);
        far.set_levels(1, 0);
        settle(4);
        check("running", running, 1);
        far.set_levels(0, 0);
        settle(4);
        check("running", running, 0);
        for (int i = 0; i < 24; i++) begin
            sw = 1'($urandom_range(0, 1));
            en = 1'($urandom_range(0, 1));
            sel = (i < 4) ? 4'(i * 5) : 4'($urandom_range(0, 15));
            t = 16'($urandom);
            if (i < 4) begin
                sw = i[0];
                en = 1'b1;
                t[sel] = i[1];
            end
            apb(1, ADDR_CTRL, 32'({sel, en}));
            far.set_levels(sw, t);
            settle(4);
            check("running", running, sw | (en & t[sel]));
            check("running small", running_s, sw | (en & (sel < 8) & t[sel]));
            apb(0, ADDR_CTRL, 0);
            check("ctrl", rd, 32'({sel, en}));
            apb(0, ADDR_STAT, 0);
            check("status", rd, stat_exp(sw | (en & t[sel]), 0, 0, sw, en & t[sel], 0));
        end
        far.set_levels(0, 0);
        apb(1, ADDR_CTRL, 32'h0000_0300);
        settle(4);
        check("running", running, 1);
        apb(0, ADDR_CTRL, 0);
        check("ctrl", rd, 32'h0000_0100);
        apb(0, ADDR_STAT, 0);
        check("status", rd, stat_exp(1, 0, 0, 0, 0, 1));
        far.set_levels(1, 0);
        apb(1, ADDR_CTRL, 32'h0000_0500);
        settle(4);
        check("running", running, 0);
        apb(1, ADDR_CTRL, 0);
        settle(4);
        check("running", running, 1);
        far.command(0, 1);
        settle(1);
        check("running", running, 0);
        apb(0, ADDR_STAT, 0);
        check("status", rd, stat_exp(0, 1, 0, 1, 0, 0));
        far.command(1, 0);
        settle(1);
        check("running", running, 1);
        apb(0, ADDR_STAT, 0);
        check("status", rd, stat_exp(1, 0, 1, 1, 0, 0));
        far.command(0, 1);
        far.set_levels(0, 0);
        settle(4);
        far.set_levels(1, 0);
        settle(4);
        check("running", running, 1);
        apb(0, ADDR_STAT, 0);
        check("status", rd, stat_exp(1, 0, 0, 1, 0, 0));
        apb(1, ADDR_CTRL, 32'h0000_0007);
        far.command(0, 1);
        far.set_levels(0, 0);
        settle(4);
        check("running", running, 0);
        far.set_levels(0, 16'h0008);
        settle(4);
        check("running", running, 1);
        far.command(1, 1);
        settle(1);
        check("running", running, 0);
        far.remote_mode();
        far.command(1, 0);
        settle(4);
        check("running", running, 1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        settle(4);
        check("running", running, 0);
        far.set_levels(1, 0);
        settle(4);
        check("running", running, 1);
        final_report();
    end
endmodule // testbench
